// ---- design/add_sub_flags.sv ----
/*
 * Add/subtract datapath with carry and overflow indicators for a 16-bit
 * processor. One operation per request; result and flags are registered.
 * Assumes the execution control drives request inputs synchronous to
 * sys_clk_i and that nothing downstream needs signed/unsigned mode.
 */
`timescale 1ns/100ps
`default_nettype none

module add_sub_flags
(
    input wire logic sys_clk_i, // Processor clock, 125 MHz
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic op_start_i, // Perform an operation this cycle
    input wire logic op_sub_i, // 1 subtract, 0 add
    input wire logic [alu_flags_pkg::WORD_W-1:0] operand_a_i, // Augend/minuend
    input wire logic [alu_flags_pkg::WORD_W-1:0] operand_b_i, // Addend/subtrahend
    output logic [alu_flags_pkg::WORD_W-1:0] result_o, // Result word
    output logic carry_o, // Carry indicator
    output logic overflow_o, // Overflow indicator
    output logic done_o // One-cycle pulse, result valid
);

    localparam int unsigned W = alu_flags_pkg::WORD_W;

    // =====================================================================
    // Helper: carry indicator from the raw adder carry
    // A subtract reports borrow, which is the absent complement-add carry
    function automatic logic carry_flag(input logic sub, input logic cout);
        carry_flag = sub ? ~cout : cout;
    endfunction

    // =====================================================================
    // Adder operands
    logic [W-1:0] adder_b;
    logic adder_cin;
    logic [W-1:0] adder_sum;
    logic c_into_sign;
    logic c_out_sign;

    // Same adder for both operations; only the second input and the carry-in change
    always_comb
    begin
        adder_b = op_sub_i ? ~operand_b_i : operand_b_i;
        adder_cin = op_sub_i;
    end

    sign_carry_adder u_adder
    (
        .addend_a_i(operand_a_i),
        .addend_b_i(adder_b),
        .carry_in_i(adder_cin),
        .sum_o(adder_sum),
        .carry_sign_in_o(c_into_sign),
        .carry_sign_out_o(c_out_sign)
    );

    // =====================================================================
    // Next state of result and flags
    logic [W-1:0] next_result;
    logic next_carry;
    logic next_overflow;
    logic next_done;

    // Flags hold between operations so later instructions can test them
    always_comb
    begin
        next_result = result_o;
        next_carry = carry_o;
        next_overflow = overflow_o;
        next_done = 1'b0;
        if (op_start_i)
        begin
            next_result = adder_sum;
            next_carry = carry_flag(op_sub_i, c_out_sign);
            // No unsigned suppression: overflow is always computed
            next_overflow = c_into_sign ^ c_out_sign;
            next_done = 1'b1;
        end
    end

    // Plain registers; reset clears both indicators
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            result_o <= alu_flags_pkg::RESULT_RST;
            carry_o <= alu_flags_pkg::CARRY_RST;
            overflow_o <= alu_flags_pkg::OVERFLOW_RST;
            done_o <= alu_flags_pkg::DONE_RST;
        end
        else
        begin
            result_o <= next_result;
            carry_o <= next_carry;
            overflow_o <= next_overflow;
            done_o <= next_done;
        end
    end

    // =====================================================================
    // Reference arithmetic for the checks below, computed independently
    logic [W:0] ref_usum;
    logic [W:0] ref_udiff;
    logic [W:0] ref_ssum;
    logic [W:0] ref_sdiff;
    logic ref_sfit;
    logic [alu_flags_pkg::EXT_W-1:0] ref_three;
    logic ref_cin;
    logic ref_cout;

    // Sign-extended and zero-extended 17-bit views of the true results
    always_comb
    begin
        ref_usum = {1'b0, operand_a_i} + {1'b0, operand_b_i};
        ref_udiff = {1'b0, operand_a_i} - {1'b0, operand_b_i};
        ref_ssum = {operand_a_i[W-1], operand_a_i}
                 + {operand_b_i[W-1], operand_b_i};
        ref_sdiff = {operand_a_i[W-1], operand_a_i}
                  - {operand_b_i[W-1], operand_b_i};
        ref_sfit = op_sub_i ? (ref_sdiff[W] == ref_sdiff[W-1])
                            : (ref_ssum[W] == ref_ssum[W-1]);
        // Three-way add restated in plain arithmetic, not the ripple chain
        ref_three = {1'b0, operand_a_i} + {1'b0, ~operand_b_i}
                  + 17'h00001;
        // Carry into the sign bit recovered from sum and operand sign bits,
        // so the overflow check does not lean on the adder's own nets
        ref_cin = op_sub_i
                ? (ref_three[W-1] ^ operand_a_i[W-1] ^ ~operand_b_i[W-1])
                : (ref_usum[W-1] ^ operand_a_i[W-1] ^ operand_b_i[W-1]);
        ref_cout = op_sub_i ? ref_three[W] : ref_usum[W];
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_add_req;
        op_start_i && (op_sub_i == alu_flags_pkg::OP_ADD);
    endsequence

    sequence s_sub_req;
        op_start_i && (op_sub_i == alu_flags_pkg::OP_SUB);
    endsequence

    // Second step of each overflow case: the flag stands after the edge
    sequence s_add_ovf;
        s_add_req ##1 overflow_o;
    endsequence

    sequence s_sub_ovf;
        s_sub_req ##1 overflow_o;
    endsequence

    a_add_carry_out: assert property (s_add_req |=>
        {carry_o, result_o} == $past(ref_usum))
        else $error("add carry or sum wrong");

    a_sub_borrow: assert property (s_sub_req |=>
        carry_o == $past(ref_udiff[W]))
        else $error("subtract borrow wrong");

    a_sub_negative: assert property ((s_sub_req ##1 carry_o) |->
        {carry_o, result_o} == $past(ref_udiff))
        else $error("borrow result not negative form");

    a_overflow_fit: assert property (op_start_i |=>
        overflow_o == !$past(ref_sfit))
        else $error("overflow does not match range");

    a_add_ovf_sign: assert property ((s_add_req ##1 overflow_o) |->
        {carry_o, result_o} == $past(ref_ssum))
        else $error("add overflow carry not sign");

    a_sub_ovf_sign: assert property ((s_sub_req ##1 overflow_o) |->
        carry_o == !$past(ref_sdiff[W])
        && result_o == $past(ref_sdiff[W-1:0]))
        else $error("subtract overflow carry not inverted sign");

    a_ovf_carries: assert property (op_start_i |=>
        overflow_o == $past(ref_cin ^ ref_cout))
        else $error("overflow not carry xor");

    a_sub_three_way: assert property (s_sub_req |=>
        result_o == $past(ref_three[W-1:0])
        && carry_o == !$past(ref_three[W]))
        else $error("subtract not complement add");

    a_flags_hold: assert property (!op_start_i |=>
        $stable(carry_o) && $stable(overflow_o) && $stable(result_o))
        else $error("flags changed without operation");

    a_done_pulse: assert property (op_start_i |=> done_o)
        else $error("done not raised after operation");

    a_reset_clear: assert property (disable iff (1'b0)
        reset_i |=> !carry_o && !overflow_o && !done_o)
        else $error("reset did not clear flags");

    a_done_single: assert property (!op_start_i |=> !done_o)
        else $error("done raised without operation");

    a_reset_result: assert property (disable iff (1'b0)
        reset_i |=> result_o == alu_flags_pkg::RESULT_RST)
        else $error("reset did not clear result");

    // Signed and unsigned views must give one word: no mode exists
    a_one_adder: assert property (op_start_i |=>
        result_o == $past(op_sub_i ? ref_sdiff[W-1:0] : ref_ssum[W-1:0]))
        else $error("result depends on number view");

    // An overflowed add cannot look like a sign-extended word
    a_add_ovf_extend: assert property (s_add_ovf |->
        carry_o != result_o[W-1])
        else $error("add overflow carry not extra top bit");

    // Inverting the carry back gives the true 17-bit signed difference
    a_sub_ovf_extend: assert property (s_sub_ovf |->
        {!carry_o, result_o} == $past(ref_sdiff))
        else $error("subtract overflow not an extended result");

    // Flag follows the signed range for every operation, unsigned use too
    a_ovf_always: assert property (op_start_i && !ref_sfit |=>
        overflow_o)
        else $error("overflow suppressed");

endmodule // add_sub_flags

`default_nettype wire

// ---- design/alu_flags_pkg.sv ----
/*
 * Constants shared by the add/subtract datapath and its flag logic.
 * Assumes a single 125 MHz processor clock and a synchronous reset.
 */
package alu_flags_pkg;

    // =====================================================================
    // Widths
    localparam int unsigned WORD_W = 16;
    localparam int unsigned EXT_W = WORD_W + 1;

    // =====================================================================
    // Values after reset
    localparam logic [WORD_W-1:0] RESULT_RST = 16'h0000;
    localparam logic CARRY_RST = 1'b0;
    localparam logic OVERFLOW_RST = 1'b0;
    localparam logic DONE_RST = 1'b0;

    // =====================================================================
    // Operation select and latency
    localparam logic OP_ADD = 1'b0;
    localparam logic OP_SUB = 1'b1;
    localparam int unsigned OP_LATENCY = 1;

endpackage : alu_flags_pkg

// ---- design/sign_carry_adder.sv ----
/*
 * Ripple adder of two words and a carry-in that exposes both the carry
 * into the sign position and the carry out of it.
 * Assumes the caller presents the second operand already inverted for a
 * subtract; purely combinational, no clock.
 */
`timescale 1ns/100ps
`default_nettype none

module sign_carry_adder
(
    input wire logic [alu_flags_pkg::WORD_W-1:0] addend_a_i, // First input
    input wire logic [alu_flags_pkg::WORD_W-1:0] addend_b_i, // Second input
    input wire logic carry_in_i, // Low-order carry
    output logic [alu_flags_pkg::WORD_W-1:0] sum_o, // Sum word
    output logic carry_sign_in_o, // Carry into the sign bit
    output logic carry_sign_out_o // Carry out of the sign bit
);

    // =====================================================================
    // Carry chain
    logic [alu_flags_pkg::WORD_W:0] chain;

    // Explicit chain so the carry into the sign bit is a real net
    always_comb
    begin
        chain = '0;
        sum_o = '0;
        chain[0] = carry_in_i;
        for (int i = 0; i < alu_flags_pkg::WORD_W; i++)
        begin
            sum_o[i] = addend_a_i[i] ^ addend_b_i[i] ^ chain[i];
            chain[i+1] = (addend_a_i[i] & addend_b_i[i])
                       | (chain[i] & (addend_a_i[i] ^ addend_b_i[i]));
        end
        carry_sign_in_o = chain[alu_flags_pkg::WORD_W-1];
        carry_sign_out_o = chain[alu_flags_pkg::WORD_W];
    end

endmodule // sign_carry_adder

`default_nettype wire

// ---- test/exec_ctrl_model.sv ----
/*
 * Stand-in for the execution control that issues add/subtract requests.
 * Assumes one bench process calls its tasks, never two at once.
 */
`timescale 1ns/100ps
`default_nettype none

module exec_ctrl_model
(
    input wire logic sys_clk_i, // Processor clock
    output logic op_start_o, // Request strobe
    output logic op_sub_o, // 1 subtract, 0 add
    output logic [alu_flags_pkg::WORD_W-1:0] operand_a_o, // First operand
    output logic [alu_flags_pkg::WORD_W-1:0] operand_b_o // Second operand
);
    // =====================================================================
    // Quiet bus at time zero
    initial
    begin
        op_start_o = 1'b0;
        op_sub_o = 1'b0;
        operand_a_o = 16'h0000;
        operand_b_o = 16'h0000;
    end

    // Present one request just after an edge; it is taken at the next one
    task automatic put(input logic s, input logic [15:0] a,
                       input logic [15:0] b);
        @(posedge sys_clk_i);
        #1;
        op_start_o = 1'b1;
        op_sub_o = s;
        operand_a_o = a;
        operand_b_o = b;
    endtask

    // Withdraw; fields inverted so a design that still samples them shows it
    task automatic idle();
        @(posedge sys_clk_i);
        #1;
        op_start_o = 1'b0;
        op_sub_o = ~op_sub_o;
        operand_a_o = ~operand_a_o;
        operand_b_o = ~operand_b_o;
    endtask
endmodule // exec_ctrl_model

`default_nettype wire

// ---- test/test_add_sub_flags.sv ----
/*
 * Self-checking bench for the add/subtract datapath and its flags.
 * Assumes the design answers one cycle after each taken request.
 */
`timescale 1ns/100ps
`default_nettype none

module test_add_sub_flags;
    logic sys_clk_i;
    logic reset_i;
    logic op_start_i;
    logic op_sub_i;
    logic [15:0] operand_a_i;
    logic [15:0] operand_b_i;
    logic [15:0] result_o;
    logic carry_o;
    logic overflow_o;
    logic done_o;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    // Table rows are {subtract, a, b}; edges of both sign and carry
    logic [32:0] ops[12] = '{{1'b0, 16'hFFFF, 16'h0001},
        {1'b0, 16'hFFFF, 16'hFFFF}, {1'b0, 16'h4000, 16'h4000},
        {1'b0, 16'h8000, 16'h8000}, {1'b0, 16'h7FFF, 16'h0001},
        {1'b0, 16'h0006, 16'h0009}, {1'b1, 16'h0000, 16'h0001},
        {1'b1, 16'h0000, 16'h000F}, {1'b1, 16'hFFFF, 16'hFFFF},
        {1'b1, 16'h7FFF, 16'hFFFE}, {1'b1, 16'h8000, 16'h0001},
        {1'b1, 16'h0001, 16'h8000}};

    // =====================================================================
    // Design, its requester, clock and hang guard
    add_sub_flags DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .op_start_i(op_start_i), .op_sub_i(op_sub_i),
        .operand_a_i(operand_a_i), .operand_b_i(operand_b_i),
        .result_o(result_o), .carry_o(carry_o),
        .overflow_o(overflow_o), .done_o(done_o));
    exec_ctrl_model m (.sys_clk_i(sys_clk_i), .op_start_o(op_start_i),
        .op_sub_o(op_sub_i), .operand_a_o(operand_a_i),
        .operand_b_o(operand_b_i));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // Whole run is well under a hundred cycles; generous ceiling
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // =====================================================================
    // Comparison helpers
    task automatic cmp_word(string n, logic [15:0] e, logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_bit(string n, logic e, logic s);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", n, e, s);
        end
    endtask
    // Expected {carry, word} from 17-bit arithmetic; carry on sub is borrow
    task automatic check_op(logic s, logic [15:0] a, logic [15:0] b);
        logic [16:0] t;
        logic v;
        t = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        v = (s ? a[15] != b[15] : a[15] == b[15]) && t[15] != a[15];
        cmp_word("result", t[15:0], result_o);
        cmp_bit("carry", t[16], carry_o);
        cmp_bit("overflow", v, overflow_o);
        cmp_bit("done", 1'b1, done_o);
    endtask

    // =====================================================================
    // Scenarios
    task automatic test_table();
        foreach (ops[i])
        begin
            m.put(ops[i][32], ops[i][31:16], ops[i][15:0]);
            m.idle();
            check_op(ops[i][32], ops[i][31:16], ops[i][15:0]);
        end
        $display("test table done");
    endtask
    task automatic test_back_to_back();
        m.put(1'b1, 16'h0000, 16'h0001);
        m.put(1'b0, 16'h4000, 16'h4000);
        check_op(1'b1, 16'h0000, 16'h0001);
        m.idle();
        check_op(1'b0, 16'h4000, 16'h4000);
        repeat (3) m.idle();
        cmp_bit("done", 1'b0, done_o);
        cmp_word("result", 16'h8000, result_o);
        cmp_bit("overflow", 1'b1, overflow_o);
        $display("test back to back done");
    endtask
    // Reset in mid-run must clear flags that were set
    task automatic test_reset();
        m.put(1'b0, 16'h8000, 16'h8000);
        m.idle();
        reset_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        cmp_bit("carry", 1'b0, carry_o);
        cmp_bit("overflow", 1'b0, overflow_o);
        cmp_word("result", 16'h0000, result_o);
        reset_i = 1'b0;
        $display("test reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    initial
    begin
        reset_i = 1'b1;
        repeat (12) @(posedge sys_clk_i);
        #1;
        reset_i = 1'b0;
        test_table();
        test_back_to_back();
        test_reset();
        test_table();
        finish_test();
    end
endmodule // test_add_sub_flags

`default_nettype wire
